//--- core/sarsq_core.sv
// 8-bit 4-channel SAR conversion sequencer with AXI4-Lite registers
// assumes comparator and trigger pin are asynchronous, timer_ovf is
// an aclk pulse; the converter clock is aclk/32 (7.8 MHz)
// What this block does
// [RULE_01] SAR loop drives DAC, takes comparator bits
// [RULE_02] each conversion lasts at least 1.61 us
// [RULE_03] fixed single: one result, own register
// [RULE_04] fixed continuous: registers 0..3, done per four
// [RULE_05] continuous modes run until settings change
// [RULE_06] scan: set channels LSB first, own registers
// [RULE_07] scan done only after whole pass
// [RULE_08] scan single one channel equals fixed
// [RULE_09] scan continuous restarts at first channel
// [RULE_10] dual: first, second, first, second
// [RULE_11] single step: one channel per start
// [RULE_12] three mode bits decoded, others undefined
// [RULE_13] timer overflow starts, ignored while busy
// [RULE_14] immediate mode starts on control write
// [RULE_15] chosen pin edge starts, ignored while busy
// [RULE_16] any start mode with any mode
// [RULE_17] limit check inside or outside, selectable
// [RULE_18] no boundary event when enable clear
// [RULE_19] early outside check on four MSBs
// [RULE_20] otherwise full eight-bit check
// [RULE_21] per-channel boundary status bits
// [RULE_22] start field: timer/stop, immediate, edge, both (code 11 here starts on the control write only, pin edges ignored)
// [RULE_23] edge select: 0 falling, 1 rising
// [RULE_24] done flag set by hardware, software clears
// [RULE_25] channel count picks fixed versus dual/scan
// [RULE_26] idle start acted on at once, unqueued
`timescale 1ns/1ps
`include "sarsq_cfg.svh"
module sarsq_core (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // start triggers
    input  wire logic              timer_ovf,
    input  wire logic              edge_trigger_pin,
    // analog front end
    input  wire logic              cmp_in,
    output sarsq_pkg::sarsq_ana_type ana,
    output logic                   adc_irq
);
    function automatic logic [1:0] lowest(input logic [3:0] m);
        lowest = m[0] ? 2'd0 : m[1] ? 2'd1 : m[2] ? 2'd2 : 2'd3;
    endfunction : lowest

    function automatic logic [3:0] drop(input logic [3:0] m,
                                       input logic [1:0] i);
        drop = m & ~(4'h1 << i);
    endfunction : drop

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `SQ_A_RES3)
              && (a != `SQ_A_GAP);
    endfunction : mapped

    logic [7:0]  ctl_q;
    logic [2:0]  mode_q;
    logic [3:0]  sel_q, bst_q;
    logic        inside_q, done_q, bnd_q, irq_q, imm_q;
    logic [7:0]  hi_q, lo_q;
    logic [7:0]  res_q [4];
    logic        aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
    logic        arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [7:0]  awaddr_q;
    logic [7:0]  wdata_q;
    logic        wlane_q;
    logic [31:0] rdata_q, rd_d;
    sarsq_pkg::sarsq_state_type st_q;
    logic [4:0]  div_q;
    logic [2:0]  ph_q, bit_q;
    logic [7:0]  sar_q, sar_nx, dac_q;
    logic [1:0]  ch_q, dst_q, slot_q, nslot, nch, ndst;
    logic [3:0]  rem_q, pool, nrem;
    logic        smp_q, early_q;
    logic [2:0]  pin_s, cmp_s;
    logic        pin_q, pin_prev_q, cmp_q;
    logic [9:0]  len_q;

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;
    assign adc_irq = irq_q;
    assign ana     = '{mux_sel: ch_q, sample: smp_q, dac: dac_q};

    // bus write handshake: address and data taken in either order
    logic wr;
    assign wr = aw_have_q && w_have_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `SQ_RESP_OK;
            awaddr_q  <= 8'h00;
            wdata_q   <= 8'h00;
            wlane_q   <= 1'b0;
        end else begin
            if (awvalid && awready_q) begin
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q  <= awaddr;
            end else if (!aw_have_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (wvalid && wready_q) begin
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q  <= wdata[7:0];
                wlane_q  <= wstrb[0];
            end else if (!w_have_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
            if (wr) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= mapped(awaddr_q) ? `SQ_RESP_OK : `SQ_RESP_ERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    logic wr_ctl, wr_mode;
    assign wr_ctl  = wr && wlane_q && awaddr_q == `SQ_A_CTL;
    assign wr_mode = wr && wlane_q && awaddr_q == `SQ_A_MODE;

    always_comb begin
        rd_d = 32'h0;
        unique case (araddr)
            `SQ_A_CTL:  rd_d[7:0] = {ctl_q[7:4], done_q, ctl_q[2:0]};
            `SQ_A_MODE: rd_d[7:0] = {bnd_q, mode_q, 4'h0};
            `SQ_A_SEL:  rd_d[3:0] = sel_q;
            `SQ_A_BCFG: rd_d[0]   = inside_q;
            `SQ_A_HI:   rd_d[7:0] = hi_q;
            `SQ_A_LO:   rd_d[7:0] = lo_q;
            `SQ_A_BST:  rd_d[3:0] = bst_q;
            default: begin
                if (mapped(araddr)) begin
                    rd_d[7:0] = res_q[araddr[3:2]];
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= `SQ_RESP_OK;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_d;
            rresp_q   <= mapped(araddr) ? `SQ_RESP_OK : `SQ_RESP_ERR;
        end else if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // software-owned settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q    <= 8'h00;
            mode_q   <= `SQ_M_STEP;
            sel_q    <= 4'h0;
            inside_q <= 1'b0;
            hi_q     <= 8'hff;
            lo_q     <= 8'h00;
        end else if (wr && wlane_q) begin
            unique case (awaddr_q)
                `SQ_A_CTL:  ctl_q    <= wdata_q;
                `SQ_A_MODE: mode_q   <= wdata_q[6:4];
                `SQ_A_SEL:  sel_q    <= wdata_q[3:0];
                `SQ_A_BCFG: inside_q <= wdata_q[0];
                `SQ_A_HI:   hi_q     <= wdata_q;
                `SQ_A_LO:   lo_q     <= wdata_q;
                default: ;
            endcase
        end
    end

    // pin and comparator: three stages, change taken when 2 and 3 agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s      <= 3'h0;
            cmp_s      <= 3'h0;
            pin_q      <= 1'b0;
            pin_prev_q <= 1'b0;
            cmp_q      <= 1'b0;
        end else begin
            pin_s <= {pin_s[1:0], edge_trigger_pin};
            cmp_s <= {cmp_s[1:0], cmp_in};
            if (pin_s[1] == pin_s[2]) pin_q <= pin_s[2];
            if (cmp_s[1] == cmp_s[2]) cmp_q <= cmp_s[2];
            pin_prev_q <= pin_q;
        end
    end

    // [RULE_22] start field decode and trigger sources
    logic [1:0] sm;
    logic       edge_ev, legal, idle, start_ev, tick, abort;
    assign sm = ctl_q[1:0];
    // [RULE_23] edge polarity
    assign edge_ev = ctl_q[`SQ_F_EDGE] ? (pin_q && !pin_prev_q)
                                       : (!pin_q && pin_prev_q);
    // [RULE_12] only four mode codes run
    assign legal = mode_q == `SQ_M_STEP || mode_q == `SQ_M_SGL
                || mode_q == `SQ_M_CONT || mode_q == `SQ_M_BRST;
    assign idle  = st_q == sarsq_pkg::ST_IDLE;
    // [RULE_13] [RULE_15] [RULE_16] [RULE_26] idle-only triggers
    assign start_ev = idle && !abort && ctl_q[`SQ_F_EN] && legal
        && sel_q != 4'h0
        && ((sm == `SQ_SM_TMR && ctl_q[`SQ_F_TMM] && timer_ovf)
         || (sm == `SQ_SM_EDG && edge_ev) || imm_q);
    assign tick  = div_q == `SQ_DIV_LAST;
    // [RULE_05] a control or mode write ends a running sequence
    assign abort = wr_ctl || wr_mode;

    // [RULE_14] immediate start latched by the control write
    always_ff @(posedge aclk) begin
        if (!aresetn) imm_q <= 1'b0;
        else imm_q <= wr_ctl && wdata_q[0];
    end

    // next conversion: channel, destination and remaining pass
    logic fin, last, done_set, again;
    assign fin  = st_q == sarsq_pkg::ST_BITS && tick && bit_q == 3'h0;
    assign last = rem_q == 4'h0;
    always_comb begin
        nslot = idle ? 2'd0 : 2'(slot_q + 2'd1);
        // [RULE_06] [RULE_09] fresh pass starts from every set bit
        pool  = (idle ? (mode_q != `SQ_M_STEP || last)
                      : mode_q == `SQ_M_BRST && last) ? sel_q : rem_q;
        nch   = lowest(pool);
        ndst  = nch;
        nrem  = drop(pool, nch);
        if (mode_q == `SQ_M_CONT) begin
            // [RULE_25] one bit fixed, more bits dual
            nch  = lowest(sel_q);
            if ((sel_q & (sel_q - 4'h1)) != 4'h0 && nslot[0]) begin
                // [RULE_10] odd slots take the second channel
                nch = lowest(drop(sel_q, lowest(sel_q)));
            end
            // [RULE_04] results fill slots 0..3
            ndst = nslot;
            nrem = 4'h0;
        end
    end

    // [RULE_03] [RULE_07] [RULE_08] [RULE_11] end of one conversion
    always_comb begin
        done_set = 1'b0;
        again    = 1'b0;
        if (fin) begin
            unique case (mode_q)
                `SQ_M_SGL: begin
                    done_set = last;
                    again    = !last;
                end
                `SQ_M_CONT: begin
                    done_set = slot_q == 2'd3;
                    again    = 1'b1;
                end
                `SQ_M_BRST: begin
                    done_set = last;
                    again    = 1'b1;
                end
                default: done_set = 1'b1;
            endcase
        end
    end

    // [RULE_01] take the comparator decision into the trial bit
    always_comb begin
        sar_nx = sar_q;
        sar_nx[bit_q] = cmp_q;
    end

    // [RULE_02] 5 sample + 8 bit ticks of 32 cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q   <= sarsq_pkg::ST_IDLE;
            div_q  <= 5'h0;
            ph_q   <= 3'h0;
            bit_q  <= `SQ_MSB;
            sar_q  <= 8'h00;
            ch_q   <= 2'd0;
            dst_q  <= 2'd0;
            slot_q <= 2'd0;
            rem_q  <= 4'h0;
            smp_q  <= 1'b0;
        end else if (abort) begin
            st_q  <= sarsq_pkg::ST_IDLE;
            rem_q <= 4'h0;
            smp_q <= 1'b0;
        end else if (start_ev || again) begin
            st_q   <= sarsq_pkg::ST_SAMPLE;
            div_q  <= 5'h0;
            ph_q   <= 3'h0;
            ch_q   <= nch;
            dst_q  <= ndst;
            slot_q <= nslot;
            rem_q  <= nrem;
            smp_q  <= 1'b1;
        end else begin
            div_q <= 5'(div_q + 5'h1);
            if (fin) begin
                st_q <= sarsq_pkg::ST_IDLE;
            end else if (tick && st_q == sarsq_pkg::ST_SAMPLE) begin
                ph_q <= 3'(ph_q + 3'h1);
                if (ph_q == `SQ_SMP_LAST) begin
                    st_q  <= sarsq_pkg::ST_BITS;
                    smp_q <= 1'b0;
                    sar_q <= 8'h00;
                    bit_q <= `SQ_MSB;
                end
            end else if (tick && st_q == sarsq_pkg::ST_BITS) begin
                sar_q <= sar_nx;
                bit_q <= 3'(bit_q - 3'h1);
            end
        end
    end

    // trial code: settled bits plus the bit under test
    always_ff @(posedge aclk) begin
        if (!aresetn) dac_q <= 8'h00;
        else if (st_q == sarsq_pkg::ST_BITS) dac_q <= sar_q | (8'h1 << bit_q);
        else dac_q <= 8'h00;
    end

    always_ff @(posedge aclk) begin
        if (fin) res_q[dst_q] <= sar_nx;
    end

    // boundary check
    logic early_hit, full_out, bnd_set;
    // [RULE_19] four settled MSBs already beyond a limit
    assign early_hit = st_q == sarsq_pkg::ST_BITS && tick
        && bit_q == `SQ_NIB_BIT && !inside_q && !early_q
        && (sar_nx[7:4] > hi_q[7:4] || sar_nx[7:4] < lo_q[7:4]);
    assign full_out = sar_nx > hi_q || sar_nx < lo_q;
    // [RULE_17] [RULE_20] full compare unless already flagged
    // [RULE_18] nothing raised while disabled
    assign bnd_set = ctl_q[`SQ_F_BIE] && (early_hit
        || (fin && !early_q && (inside_q ? !full_out : full_out)));

    always_ff @(posedge aclk) begin
        if (!aresetn || start_ev || again) early_q <= 1'b0;
        else if (early_hit) early_q <= 1'b1;
    end

    // [RULE_24] [RULE_21] sticky flags, a set beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            bnd_q  <= 1'b0;
            bst_q  <= 4'h0;
            irq_q  <= 1'b0;
        end else begin
            if (done_set) done_q <= 1'b1;
            else if (wr_ctl && !wdata_q[`SQ_F_DONE]) done_q <= 1'b0;
            if (bnd_set) bnd_q <= 1'b1;
            else if (wr_mode && !wdata_q[`SQ_F_BND]) bnd_q <= 1'b0;
            if (bnd_set) bst_q <= bst_q | (4'h1 << ch_q);
            else if (wr && wlane_q && awaddr_q == `SQ_A_BST)
                bst_q <= bst_q & ~wdata_q[3:0];
            irq_q <= (done_q && ctl_q[`SQ_F_DIE])
                  || (bnd_q && ctl_q[`SQ_F_BIE]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || start_ev || again) len_q <= 10'h0;
        else if (!idle) len_q <= 10'(len_q + 10'h1);
    end

    a_conv_len: assert property ( // [RULE_02]
        @(posedge aclk) disable iff (!aresetn)
        fin |-> len_q >= 10'(`SQ_CONV_MIN - 1))
        else $error("conversion shorter than minimum");
    a_start_cause: assert property ( // [RULE_13]
        @(posedge aclk) disable iff (!aresetn)
        idle ##1 st_q == sarsq_pkg::ST_SAMPLE |-> $past(start_ev))
        else $error("conversion began without a trigger");
    a_imm_start: assert property ( // [RULE_14]
        @(posedge aclk) disable iff (!aresetn)
        wr_ctl && wdata_q[1:0] == `SQ_SM_IMM && wdata_q[`SQ_F_EN]
        && legal && sel_q != 4'h0 && !wr_mode
        |-> ##2 st_q == sarsq_pkg::ST_SAMPLE)
        else $error("immediate start not taken");
    a_step_stop: assert property ( // [RULE_11]
        @(posedge aclk) disable iff (!aresetn)
        fin && mode_q == `SQ_M_STEP |=> idle && done_q)
        else $error("single step did not stop");
    a_pass_done: assert property ( // [RULE_07]
        @(posedge aclk) disable iff (!aresetn)
        done_set && mode_q != `SQ_M_CONT && mode_q != `SQ_M_STEP
        |-> rem_q == 4'h0)
        else $error("done raised mid pass");
    a_result_store: assert property ( // [RULE_03]
        @(posedge aclk) disable iff (!aresetn)
        fin && mode_q == `SQ_M_SGL |=> res_q[$past(dst_q)] == $past(sar_nx)
        && $past(dst_q) == $past(ch_q))
        else $error("result not in channel register");
    a_bnd_gate: assert property ( // [RULE_18]
        @(posedge aclk) disable iff (!aresetn)
        !ctl_q[`SQ_F_BIE] && !bnd_q |=> !bnd_q)
        else $error("boundary flag while disabled");
    a_early_flag: assert property ( // [RULE_21]
        @(posedge aclk) disable iff (!aresetn)
        early_hit && ctl_q[`SQ_F_BIE] |=> bnd_q && bst_q[$past(ch_q)])
        else $error("early boundary not flagged");
    a_cont_slot: assert property ( // [RULE_04]
        @(posedge aclk) disable iff (!aresetn)
        fin && mode_q == `SQ_M_CONT && !abort |=> ##1 dst_q == $past(nslot, 2))
        else $error("continuous slot order broken");
endmodule : sarsq_core

//--- common/sarsq_cfg.svh
// register map, field positions and timing counts of the sequencer
// assumes a 250 MHz aclk and 8-bit register data in the low byte
`ifndef SARSQ_CFG_SVH
`define SARSQ_CFG_SVH
`define SQ_A_CTL   8'h00
`define SQ_A_MODE  8'h04
`define SQ_A_SEL   8'h08
`define SQ_A_BCFG  8'h0c
`define SQ_A_HI    8'h10
`define SQ_A_LO    8'h14
`define SQ_A_BST   8'h18
`define SQ_A_GAP   8'h1c
`define SQ_A_RES0  8'h20
`define SQ_A_RES3  8'h2c
`define SQ_F_BIE   7
`define SQ_F_DIE   6
`define SQ_F_TMM   5
`define SQ_F_EDGE  4
`define SQ_F_DONE  3
`define SQ_F_EN    2
`define SQ_F_BND   7
`define SQ_SM_TMR  2'b00
`define SQ_SM_IMM  2'b01
`define SQ_SM_EDG  2'b10
`define SQ_M_STEP  3'b000
`define SQ_M_SGL   3'b001
`define SQ_M_CONT  3'b010
`define SQ_M_BRST  3'b100
`define SQ_RESP_OK  2'b00
`define SQ_RESP_ERR 2'b10
`define SQ_CLK_MHZ 250
`define SQ_CONV_NS 1610
`define SQ_CONV_MIN ((`SQ_CONV_NS * `SQ_CLK_MHZ + 999) / 1000)
`define SQ_DIV_LAST 5'h1f
`define SQ_SMP_LAST 3'h4
`define SQ_MSB     3'h7
`define SQ_NIB_BIT 3'h4
`endif

//--- common/sarsq_pkg.sv
// types shared by the sequencer core and its bench
// no assumptions beyond the cfg header
package sarsq_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_BITS} sarsq_state_type;
    typedef struct packed {
        logic [1:0] mux_sel;
        logic       sample;
        logic [7:0] dac;
    } sarsq_ana_type;
endpackage : sarsq_pkg

//--- sim/sarsq_afe_model.sv
// analog front end model: mux, sample-and-hold and comparator
// assumes ana comes from the sequencer and levels from the bench
`timescale 1ns/1ps
module sarsq_afe_model (
    // clock
    input  wire logic                     aclk,
    // sequencer side
    input  wire sarsq_pkg::sarsq_ana_type ana,
    input  wire logic [3:0][7:0]          vin,
    output logic                          cmp_in
);
    logic [7:0] held_q = 8'h00;
    always @(posedge aclk) begin
        if (ana.sample) begin
            held_q <= vin[ana.mux_sel];
        end
    end
    assign cmp_in = (held_q >= ana.dac);
endmodule : sarsq_afe_model

//--- sim/tb.sv
// self-checking bench for the conversion sequencer
// assumes the front end model answers on cmp_in
`timescale 1ns/1ps
`include "sarsq_cfg.svh"
module tb;
    logic            aclk = 1'b0;
    logic            aresetn = 1'b0;
    logic [7:0]      awaddr = 8'h00;
    logic [7:0]      araddr = 8'h00;
    logic [31:0]     wdata = 32'h0;
    logic [3:0]      wstrb = 4'hf;
    logic            awvalid = 1'b0;
    logic            wvalid = 1'b0;
    logic            arvalid = 1'b0;
    logic            bready = 1'b1;
    logic            rready = 1'b1;
    logic            timer_ovf = 1'b0;
    logic            edge_trigger_pin = 1'b0;
    logic            awready, wready, bvalid, arready, rvalid;
    logic            cmp_in, adc_irq;
    logic [1:0]      bresp, rresp, resp;
    logic [31:0]     rdata;
    logic [3:0][7:0] vin = '0;
    sarsq_pkg::sarsq_ana_type ana;
    int              fail_count = 0;
    int              n_checks = 0;
    int              n;

    always #2 aclk = ~aclk;

    sarsq_core sarsq_core_inst (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .timer_ovf,
        .edge_trigger_pin, .cmp_in, .ana, .adc_irq
    );
    sarsq_afe_model sarsq_afe_model_inst (.aclk, .ana, .vin, .cmp_in);

    task automatic chk(input string s, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask : chk

    task automatic summarize;
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    // bready held high throughout, so only valids move here
    // a missing answer is left to the watchdog
    task automatic wr(input logic [7:0] a, d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
    endtask : wr

    task automatic rdc(input logic [7:0] a, e);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        resp = rresp;
        chk($sformatf("rd %h", a), e, rdata[7:0]);
    endtask : rdc

    task automatic wirq(input int lim);
        n = 0;
        while (adc_irq !== 1'b1 && n < lim) begin
            @(posedge aclk);
            n++;
        end
        chk("irq", 8'h01, {7'h0, adc_irq});
    endtask : wirq

    task automatic cres(input logic [31:0] e);
        for (int i = 0; i < 4; i++) rdc(8'(`SQ_A_RES0 + 4 * i), e[8*i +: 8]);
    endtask : cres

    task automatic wsmp(input logic [1:0] ch);
        n = 0;
        while (ana.sample !== 1'b1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        chk("mux_sel", {6'h0, ch}, {6'h0, ana.mux_sel});
        chk("sample", 8'h01, {7'h0, ana.sample});
        chk("dac", 8'h00, ana.dac);
    endtask : wsmp

    task automatic ovf;
        timer_ovf <= 1'b1;
        @(posedge aclk);
        timer_ovf <= 1'b0;
    endtask : ovf

    task automatic bnd(input logic [7:0] c, v, k, me, be, input int lo, hi);
        wr(`SQ_A_CTL, 8'h00);
        wr(`SQ_A_BST, 8'h0f);
        wr(`SQ_A_MODE, 8'h10);
        wr(`SQ_A_BCFG, c);
        vin[0] <= v;
        wr(`SQ_A_CTL, k);
        wirq(600);
        chk("bnd_time", 8'h01, {7'h0, n >= lo && n <= hi});
        rdc(`SQ_A_MODE, me);
        rdc(`SQ_A_BST, be);
    endtask : bnd

    initial begin
        #100000;
        fail_count++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdc(`SQ_A_CTL, 8'h00);
        rdc(`SQ_A_MODE, 8'h00);
        rdc(`SQ_A_HI, 8'hff);
        rdc(`SQ_A_LO, 8'h00);
        rdc(`SQ_A_BST, 8'h00);
        rdc(`SQ_A_GAP, 8'h00);
        chk("rresp", {6'h0, `SQ_RESP_ERR}, {6'h0, resp});
        wr(`SQ_A_GAP, 8'hff);
        chk("bresp", {6'h0, `SQ_RESP_ERR}, {6'h0, resp});
        // fixed channel, one shot
        vin[2] <= 8'h5a;
        wr(`SQ_A_SEL, 8'h04);
        wr(`SQ_A_MODE, 8'h10);
        wr(`SQ_A_CTL, 8'h45);
        wirq(600);
        chk("conv_len", 8'h01, {7'h0, n >= 403});
        rdc(`SQ_A_RES0 + 8'h08, 8'h5a);
        rdc(`SQ_A_CTL, 8'h4d);
        wr(`SQ_A_CTL, 8'h40);
        repeat (2) @(posedge aclk);
        chk("irq_clr", 8'h00, {7'h0, adc_irq});
        // scan single over three channels
        vin[0] <= 8'ha1;
        vin[1] <= 8'hb2;
        vin[3] <= 8'hc4;
        wr(`SQ_A_SEL, 8'h0b);
        wr(`SQ_A_CTL, 8'h45);
        wirq(1500);
        chk("scan_len", 8'h01, {7'h0, n >= 1209});
        cres(32'hc45ab2a1);
        wr(`SQ_A_CTL, 8'h40);
        // dual channel continuous
        vin[1] <= 8'h3c;
        vin[2] <= 8'h96;
        wr(`SQ_A_SEL, 8'h06);
        wr(`SQ_A_MODE, 8'h20);
        wr(`SQ_A_CTL, 8'h45);
        wirq(2000);
        chk("dual_len", 8'h01, {7'h0, n >= 1612});
        wsmp(2'h1);
        cres(32'h963c963c);
        wr(`SQ_A_CTL, 8'h40);
        // fixed channel continuous
        vin[0] <= 8'h77;
        wr(`SQ_A_SEL, 8'h01);
        wr(`SQ_A_CTL, 8'h47);
        wirq(2000);
        wsmp(2'h0);
        cres(32'h77777777);
        wr(`SQ_A_CTL, 8'h40);
        // scan continuous
        vin[0] <= 8'h12;
        vin[3] <= 8'hed;
        wr(`SQ_A_SEL, 8'h09);
        wr(`SQ_A_MODE, 8'h40);
        wr(`SQ_A_CTL, 8'h45);
        wirq(1000);
        wsmp(2'h0);
        cres(32'hed777712);
        wr(`SQ_A_CTL, 8'h40);
        // undefined mode code must never start
        wr(`SQ_A_MODE, 8'h30);
        wr(`SQ_A_CTL, 8'h45);
        repeat (500) @(posedge aclk);
        chk("undef", 8'h00, {7'h0, adc_irq});
        // timer start, stop mode first
        vin[0] <= 8'h0f;
        vin[1] <= 8'hf0;
        wr(`SQ_A_SEL, 8'h03);
        wr(`SQ_A_MODE, 8'h00);
        wr(`SQ_A_CTL, 8'h44);
        ovf();
        repeat (500) @(posedge aclk);
        chk("stop", 8'h00, {7'h0, adc_irq});
        wr(`SQ_A_CTL, 8'h64);
        ovf();
        repeat (10) @(posedge aclk);
        ovf();
        wirq(600);
        repeat (450) @(posedge aclk);
        rdc(`SQ_A_RES0, 8'h0f);
        rdc(`SQ_A_RES0 + 8'h04, 8'h77);
        ovf();
        repeat (440) @(posedge aclk);
        rdc(`SQ_A_RES0 + 8'h04, 8'hf0);
        // rising edge start, falling edge ignored
        vin[3] <= 8'h3e;
        wr(`SQ_A_SEL, 8'h08);
        wr(`SQ_A_MODE, 8'h10);
        edge_trigger_pin <= 1'b1;
        repeat (10) @(posedge aclk);
        wr(`SQ_A_CTL, 8'h56);
        edge_trigger_pin <= 1'b0;
        repeat (500) @(posedge aclk);
        chk("fall", 8'h00, {7'h0, adc_irq});
        edge_trigger_pin <= 1'b1;
        wirq(600);
        rdc(`SQ_A_RES0 + 8'h0c, 8'h3e);
        // boundary limits
        wr(`SQ_A_SEL, 8'h01);
        wr(`SQ_A_HI, 8'h80);
        wr(`SQ_A_LO, 8'h20);
        bnd(8'h00, 8'hf0, 8'h85, 8'h90, 8'h01, 250, 400);
        bnd(8'h00, 8'h85, 8'h85, 8'h90, 8'h01, 403, 440);
        bnd(8'h01, 8'h80, 8'h85, 8'h90, 8'h01, 403, 440);
        bnd(8'h01, 8'h10, 8'h45, 8'h10, 8'h00, 403, 440);
        bnd(8'h00, 8'hf0, 8'h45, 8'h10, 8'h00, 403, 440);
        summarize();
    end
endmodule : tb
